// >>> shared/sdc_params.svh
// Constants for the command decoder and data mask block
// Summary of operation
// (R1) A high byte mask sample puts the data buffers it controls into high impedance.
// (R2) On reads the byte mask gates the output word two clocks later.
// (R3) On writes the byte mask blocks same-edge data with zero latency.
// (R4) Sixteen-bit words have separate low and high byte masks, each gating its eight-bit lane.
// (R5) Commands decode from select and the three strobes sampled at the rising edge.
// (R6) Normal commands need clock enable high one clock before the command edge.
// (R7) Strobe patterns decode to activate, read, write, precharge, mode set, nop, stop.
// (R8) Bank commands use bank selects; activate needs idle bank, read/write active bank.
// (R9) Refresh pattern from idle: enable high auto refresh, enable low self refresh.
// (R10) Enable falling with nop or deselect enters power down; rising exits.
// (R11) Power down entry during a burst gives clock suspend instead.
// (R12) Chip select high ignores new commands; running operations continue.
// (R13) Read or write with auto-precharge bit high precharges the bank at burst end.
// (R14) Precharge with auto-precharge bit high closes all four banks.
// (R15) Commands illegal for current state act as no-operation.
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH
`define SDC_DW 16
`define SDC_AW 12
`define SDC_NB 4
`define SDC_AUTO_PRECHARGE_BIT 10
`define SDC_LO_MSB 7
`define SDC_HI_LSB 8
`define SDC_RD_LAT 2
`define SDC_BL_MSB 2
`define SDC_BL_LSB 0
`define SDC_BL_RST 3'h3
`endif

// >>> shared/sdc_pkg.sv
// Types shared by the command decoder
`default_nettype none
package sdc_pkg;
	typedef enum logic [3:0] {
		SDC_NOP, SDC_ACT, SDC_RD, SDC_WR, SDC_PRE, SDC_MRS, SDC_REF, SDC_STOP, SDC_DESEL
	} sdc_cmd_e;
	typedef enum logic [1:0] {
		SDC_RUN, SDC_PDN, SDC_SREF, SDC_SUSP
	} sdc_mode_e;
endpackage : sdc_pkg
`default_nettype wire

// >>> rtl/sdc_decode.sv
// Command decoder, bank tracking and data masking of the memory device
`timescale 1ns/1ps
`default_nettype none
`include "sdc_params.svh"
module sdc_decode (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CKE,
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic BANK_SEL_0,
	input wire logic BANK_SEL_1,
	input wire logic [`SDC_AW-1:0] ADDR,
	input wire logic LOW_BYTE_MASK,
	input wire logic HIGH_BYTE_MASK,
	input wire logic [`SDC_DW-1:0] DQ_IN,
	input wire logic [`SDC_DW-1:0] RD_DATA,
	output logic [`SDC_DW-1:0] DQ_OUT,
	output logic [1:0] DQ_OE,
	output logic [`SDC_DW-1:0] WR_DATA,
	output logic [1:0] WR_BYTE_EN,
	output logic WR_VALID,
	output logic RD_REQ,
	output logic [`SDC_NB-1:0] BANK_ACTIVE,
	output logic [1:0] POWER_MODE,
	output logic REFRESH_PULSE,
	output logic MODE_SET_PULSE,
	output logic [`SDC_AW-1:0] MODE_WORD,
	output logic BURST_BUSY
);
	// Reset release through two flops
	logic rst_s1_q, rst_n_q;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// Strobe decoding, shared by the decoder and its checks
	// (R5) strobes sampled at edge
	function automatic sdc_pkg::sdc_cmd_e dec(input logic cs, input logic r,
			input logic c, input logic w);
		sdc_pkg::sdc_cmd_e k;
		k = sdc_pkg::SDC_NOP;
		if (cs)
			k = sdc_pkg::SDC_DESEL;
		else
			case ({r, c, w})
				3'h3: k = sdc_pkg::SDC_ACT;
				3'h5: k = sdc_pkg::SDC_RD;
				3'h4: k = sdc_pkg::SDC_WR;
				3'h2: k = sdc_pkg::SDC_PRE;
				3'h0: k = sdc_pkg::SDC_MRS;
				3'h1: k = sdc_pkg::SDC_REF;
				3'h6: k = sdc_pkg::SDC_STOP;
				default: k = sdc_pkg::SDC_NOP;
			endcase
		return k;
	endfunction : dec

	sdc_pkg::sdc_cmd_e cmd;
	logic [1:0] bsel;
	logic [1:0] mask;
	assign bsel = {BANK_SEL_1, BANK_SEL_0};
	assign mask = {HIGH_BYTE_MASK, LOW_BYTE_MASK};

	// Core state: banks, burst, power mode
	logic cke_q, cke_d;
	logic [`SDC_NB-1:0] bank_q, bank_d, append_q, append_d;
	logic [2:0] cnt_q, cnt_d;
	logic [1:0] bb_q, bb_d;
	logic rd_q, rd_d, wr_q, wr_d;
	sdc_pkg::sdc_mode_e mode_q, mode_d;
	logic [`SDC_AW-1:0] mw_q, mw_d;
	logic ref_q, ref_d, mrs_q, mrs_d;
	logic burst, go;
	assign burst = rd_q | wr_q;

	always_comb begin
		cmd = dec(CS_N, RAS_N, CAS_N, WE_N);
		cke_d = CKE;
		bank_d = bank_q;
		append_d = append_q;
		cnt_d = cnt_q;
		bb_d = bb_q;
		rd_d = rd_q;
		wr_d = wr_q;
		mode_d = mode_q;
		mw_d = mw_q;
		ref_d = 1'b0;
		mrs_d = 1'b0;
		// (R6) earlier enable gates
		go = cke_q && mode_q == sdc_pkg::SDC_RUN;
		// Burst advances only while clock is enabled
		if (burst && go && CKE) begin
			if (cnt_q == 3'h0) begin
				rd_d = 1'b0;
				wr_d = 1'b0;
				// (R13) auto precharge at end
				if (append_q[bb_q]) begin
					bank_d[bb_q] = 1'b0;
					append_d[bb_q] = 1'b0;
				end
			end else
				cnt_d = cnt_q - 3'h1;
		end
		case (mode_q)
			sdc_pkg::SDC_RUN: begin
				// (R10) power down entry, (R11) suspend during burst
				if (cke_q && !CKE && (cmd == sdc_pkg::SDC_NOP || cmd == sdc_pkg::SDC_DESEL)) begin
					mode_d = burst ? sdc_pkg::SDC_SUSP : sdc_pkg::SDC_PDN;
					rd_d = rd_q;
					wr_d = wr_q;
					cnt_d = cnt_q;
				end else if (go) begin
					// (R7) (R8) (R12) (R15) legal commands only
					case (cmd)
						sdc_pkg::SDC_ACT:
							if (!bank_q[bsel])
								bank_d[bsel] = 1'b1;
						sdc_pkg::SDC_RD, sdc_pkg::SDC_WR:
							if (bank_q[bsel]) begin
								rd_d = cmd == sdc_pkg::SDC_RD;
								wr_d = cmd == sdc_pkg::SDC_WR;
								bb_d = bsel;
								cnt_d = mw_q[`SDC_BL_MSB:`SDC_BL_LSB];
								append_d[bsel] = ADDR[`SDC_AUTO_PRECHARGE_BIT];
							end
						// (R14) all banks or one
						sdc_pkg::SDC_PRE:
							if (ADDR[`SDC_AUTO_PRECHARGE_BIT])
								bank_d = '0;
							else
								bank_d[bsel] = 1'b0;
						sdc_pkg::SDC_MRS:
							if (bank_q == '0 && !burst) begin
								mw_d = ADDR;
								mrs_d = 1'b1;
							end
						// (R9) refresh or self refresh
						sdc_pkg::SDC_REF:
							if (bank_q == '0 && !burst) begin
								if (CKE)
									ref_d = 1'b1;
								else
									mode_d = sdc_pkg::SDC_SREF;
							end
						sdc_pkg::SDC_STOP: begin
							rd_d = 1'b0;
							wr_d = 1'b0;
						end
						default: ;
					endcase
				end
			end
			default:
				// (R9) (R10) exit on enable rising with nop
				if (CKE && (cmd == sdc_pkg::SDC_NOP || cmd == sdc_pkg::SDC_DESEL))
					mode_d = sdc_pkg::SDC_RUN;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cke_q <= 1'b0;
			bank_q <= '0;
			append_q <= '0;
			cnt_q <= 3'h0;
			bb_q <= 2'h0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			mode_q <= sdc_pkg::SDC_RUN;
			mw_q <= {{(`SDC_AW-3){1'b0}}, `SDC_BL_RST};
			ref_q <= 1'b0;
			mrs_q <= 1'b0;
		end else begin
			cke_q <= cke_d;
			bank_q <= bank_d;
			append_q <= append_d;
			cnt_q <= cnt_d;
			bb_q <= bb_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			mode_q <= mode_d;
			mw_q <= mw_d;
			ref_q <= ref_d;
			mrs_q <= mrs_d;
		end
	end

	// Data path: read mask pipeline and registered write
	logic [`SDC_RD_LAT*2-1:0] mpipe_q, mpipe_d;
	logic [1:0] oe_q, oe_d;
	logic [`SDC_DW-1:0] dout_q, dout_d, wd_q, wd_d;
	logic [1:0] wbe_q, wbe_d;
	logic wv_q, wv_d, wcyc;
	assign wcyc = (wr_q || wr_d) && go && CKE;

	always_comb begin
		// (R2) mask sampled now gates the word two clocks later
		mpipe_d = {mpipe_q[1:0], mask};
		// (R1) (R4) high mask tristates its own lane
		oe_d = {2{rd_q}} & ~mpipe_q[`SDC_RD_LAT*2-1:`SDC_RD_LAT];
		dout_d = RD_DATA;
		// (R3) (R4) write mask with zero latency per lane
		wv_d = wcyc && mask != 2'h3;
		wbe_d = wcyc ? ~mask : 2'h0;
		wd_d = DQ_IN;
	end

	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mpipe_q <= '1;
			oe_q <= 2'h0;
			dout_q <= '0;
			wd_q <= '0;
			wbe_q <= 2'h0;
			wv_q <= 1'b0;
		end else begin
			mpipe_q <= mpipe_d;
			oe_q <= oe_d;
			dout_q <= dout_d;
			wd_q <= wd_d;
			wbe_q <= wbe_d;
			wv_q <= wv_d;
		end
	end

	assign DQ_OUT = dout_q;
	assign DQ_OE = oe_q;
	assign WR_DATA = wd_q;
	assign WR_BYTE_EN = wbe_q;
	assign WR_VALID = wv_q;
	assign RD_REQ = rd_q;
	assign BANK_ACTIVE = bank_q;
	assign POWER_MODE = mode_q;
	assign REFRESH_PULSE = ref_q;
	assign MODE_SET_PULSE = mrs_q;
	assign MODE_WORD = mw_q;
	assign BURST_BUSY = burst;

	// Checks
	// (R1)
	mask_tristate_a: assert property (@(posedge CLK) disable iff (!rst_n_q) // R1
		$past(mask[0], 2) |-> ##1 !DQ_OE[0]) else $error("low lane driven under mask");
	// (R2)
	read_lat_a: assert property (@(posedge CLK) disable iff (!rst_n_q) // R2
		rd_q && !$past(mask[1], 2) |=> DQ_OE[1]) else $error("read lane not enabled");
	// (R3)
	write_mask_a: assert property (@(posedge CLK) disable iff (!rst_n_q) // R3
		mask == 2'h3 |=> !WR_VALID) else $error("masked write stored");
	// (R6)
	cke_prev_a: assert property (@(posedge CLK) disable iff (!rst_n_q) // R6
		!cke_q && mode_q == sdc_pkg::SDC_RUN |=> $stable(BANK_ACTIVE)) else $error("cmd without cke");
	// (R8)
	activate_a: assert property (@(posedge CLK) disable iff (!rst_n_q) // R8
		go && cmd == sdc_pkg::SDC_ACT && !(cke_q && !CKE) |=> BANK_ACTIVE[$past(bsel)])
		else $error("activate lost");
	// (R9)
	self_ref_a: assert property (@(posedge CLK) disable iff (!rst_n_q) // R9
		go && cmd == sdc_pkg::SDC_REF && bank_q == '0 && !burst && !CKE
		|=> POWER_MODE == 2'h2) else $error("no self refresh");
	// (R11)
	suspend_a: assert property (@(posedge CLK) disable iff (!rst_n_q) // R11
		mode_q == sdc_pkg::SDC_RUN && burst && cke_q && !CKE && CS_N |=> POWER_MODE == 2'h3)
		else $error("no suspend");
	// (R12)
	deselect_a: assert property (@(posedge CLK) disable iff (!rst_n_q) // R12
		CS_N && !burst |=> $stable(BANK_ACTIVE)) else $error("deselect changed banks");
	// (R14)
	pre_all_a: assert property (@(posedge CLK) disable iff (!rst_n_q) // R14
		go && cmd == sdc_pkg::SDC_PRE && ADDR[`SDC_AUTO_PRECHARGE_BIT] && CKE && !burst
		|=> BANK_ACTIVE == '0)
		else $error("precharge all missed");
endmodule : sdc_decode
`default_nettype wire

// >>> dv/sdc_ctrl_model.sv
// Memory controller model that drives the command, address, mask and data pins
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model (
	input wire logic clk,
	output logic cke,
	output logic [3:0] cmd_n,
	output logic [1:0] bank_sel,
	output logic [11:0] addr,
	output logic [1:0] mask,
	output logic [15:0] dq
);
	// Idle as a no-operation with clock enable high
	initial begin
		cke = 1'b1;
		cmd_n = 4'h7;
		bank_sel = 2'h0;
		addr = 12'h000;
		mask = 2'h0;
		dq = 16'h0000;
	end
	// pins change at the falling edge and stand valid across one rising edge
	task automatic cmd(input logic ck, input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [15:0] d, input logic [1:0] m);
		@(negedge clk);
		cke = ck;
		cmd_n = c;
		bank_sel = b;
		addr = a;
		mask = m;
		dq = d;
		@(negedge clk);
		// Bank, address and data lines flip and the command returns to no-operation so a stale value is never mistaken for a live one
		cmd_n = 4'h7;
		bank_sel = ~b;
		addr = ~a;
		dq = ~d;
	endtask : cmd
endmodule : sdc_ctrl_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the command decoder and data mask block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cke;
	logic [3:0] cmd_n;
	logic [1:0] bs;
	logic [11:0] addr;
	logic [1:0] mask;
	logic [15:0] dq;
	logic [15:0] dq_out;
	logic [1:0] dq_oe;
	logic [15:0] wr_data;
	logic [1:0] wr_byte_en;
	logic wr_valid;
	logic rd_req;
	logic [3:0] bank_active;
	logic [1:0] power_mode;
	logic refresh_pulse;
	logic mode_set_pulse;
	logic [11:0] mode_word;
	logic burst_busy;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	sdc_ctrl_model i_ctrl (.clk(clk), .cke(cke), .cmd_n(cmd_n), .bank_sel(bs), .addr(addr),
		.mask(mask), .dq(dq));
	sdc_decode i_dut (.CLK(clk), .RST_N(rst_n), .CKE(cke), .CS_N(cmd_n[3]), .RAS_N(cmd_n[2]),
		.CAS_N(cmd_n[1]), .WE_N(cmd_n[0]), .BANK_SEL_0(bs[0]), .BANK_SEL_1(bs[1]),
		.ADDR(addr), .LOW_BYTE_MASK(mask[0]), .HIGH_BYTE_MASK(mask[1]), .DQ_IN(dq),
		.RD_DATA(16'h5a3c), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .WR_DATA(wr_data),
		.WR_BYTE_EN(wr_byte_en), .WR_VALID(wr_valid), .RD_REQ(rd_req),
		.BANK_ACTIVE(bank_active), .POWER_MODE(power_mode), .REFRESH_PULSE(refresh_pulse),
		.MODE_SET_PULSE(mode_set_pulse), .MODE_WORD(mode_word), .BURST_BUSY(burst_busy));
	task automatic end_sim();
		if (mismatches == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Reset values and mode set
	task automatic t_mode();
		chk("banks", 16'h0, 16'(bank_active));
		chk("mode", 16'h3, 16'(mode_word));
		i_ctrl.cmd(1, 4'h0, 0, 12'h007, 0, 0);
		chk("mset", 16'h1, 16'(mode_set_pulse));
		chk("mode", 16'h7, 16'(mode_word));
		i_ctrl.cmd(1, 4'h1, 0, 0, 0, 0);
		chk("refr", 16'h1, 16'(refresh_pulse));
		i_ctrl.cmd(1, 4'hb, 0, 0, 0, 0);
		chk("banks", 16'h0, 16'(bank_active));
	endtask : t_mode
	// Read under a low-lane mask, clock suspend mid-burst, illegal read
	task automatic t_read();
		i_ctrl.cmd(1, 4'h3, 1, 0, 0, 0);
		chk("banks", 16'h2, 16'(bank_active));
		i_ctrl.cmd(1, 4'h5, 1, 0, 0, 2'b01);
		chk("rdreq", 16'h1, 16'(rd_req));
		chk("busy", 16'h1, 16'(burst_busy));
		chk("oe", 16'h0, 16'(dq_oe));
		@(negedge clk);
		chk("oe", 16'h3, 16'(dq_oe));
		chk("dout", 16'h5a3c, dq_out);
		repeat (2) @(negedge clk);
		chk("oe", 16'h2, 16'(dq_oe));
		i_ctrl.cmd(0, 4'h7, 0, 0, 0, 2'b01);
		chk("pmode", 16'h3, 16'(power_mode));
		i_ctrl.cmd(1, 4'h7, 0, 0, 0, 0);
		chk("pmode", 16'h0, 16'(power_mode));
		repeat (12) @(negedge clk);
		i_ctrl.cmd(1, 4'h5, 0, 0, 0, 0);
		chk("rdreq", 16'h0, 16'(rd_req));
		i_ctrl.cmd(1, 4'h5, 1, 0, 0, 0);
		chk("rdreq", 16'h1, 16'(rd_req));
		i_ctrl.cmd(1, 4'h6, 0, 0, 0, 0);
		chk("rdreq", 16'h0, 16'(rd_req));
		chk("busy", 16'h0, 16'(burst_busy));
	endtask : t_read
	// Write with high lane masked and auto-precharge
	task automatic t_write();
		i_ctrl.cmd(1, 4'h4, 1, 12'h400, 16'hbeef, 2'b10);
		chk("wvalid", 16'h1, 16'(wr_valid));
		chk("wben", 16'h1, 16'(wr_byte_en));
		chk("wdata", 16'h00ef, wr_data & 16'h00ff);
		repeat (12) @(negedge clk);
		chk("banks", 16'h0, 16'(bank_active));
	endtask : t_write
	// Single-bank and all-bank precharge
	task automatic t_pre();
		i_ctrl.cmd(1, 4'h3, 0, 0, 0, 0);
		i_ctrl.cmd(1, 4'h3, 3, 0, 0, 0);
		chk("banks", 16'h9, 16'(bank_active));
		i_ctrl.cmd(1, 4'h2, 0, 0, 0, 0);
		chk("banks", 16'h8, 16'(bank_active));
		i_ctrl.cmd(0, 4'h3, 1, 0, 0, 0);
		i_ctrl.cmd(1, 4'h3, 2, 0, 0, 0);
		chk("banks", 16'ha, 16'(bank_active));
		i_ctrl.cmd(1, 4'h2, 2, 12'h400, 0, 0);
		chk("banks", 16'h0, 16'(bank_active));
	endtask : t_pre
	// Power down and self refresh entry and exit
	task automatic t_power();
		i_ctrl.cmd(0, 4'h7, 0, 0, 0, 0);
		chk("pmode", 16'h1, 16'(power_mode));
		i_ctrl.cmd(1, 4'h7, 0, 0, 0, 0);
		chk("pmode", 16'h0, 16'(power_mode));
		i_ctrl.cmd(0, 4'h1, 0, 0, 0, 0);
		chk("pmode", 16'h2, 16'(power_mode));
		i_ctrl.cmd(1, 4'h7, 0, 0, 0, 0);
		chk("pmode", 16'h0, 16'(power_mode));
	endtask : t_power
	// Cut a hang short well past the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		t_mode();
		t_read();
		t_write();
		t_pre();
		t_power();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
